// [tbtc_ctrl.sv]
`timescale 1ns/1ns
module tbtc_ctrl #(
    parameter int unsigned BAUD = tbtc_pkg::BAUD_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ext_reset,
    // serial link
    input wire logic sense_in,
    output logic flag_out,
    // status
    output logic [7:0] stored_count,
    output logic halted
);
    // 18 bits so that the slowest link rate still fits the divider
    localparam logic [17:0] BIT_DIV = 18'(tbtc_pkg::CLK_HZ / BAUD - 1);
    localparam logic [7:0] STORE_MAX = 8'(tbtc_pkg::STORE_MAX);

    typedef struct packed {
        logic er1, er2;
        tbtc_pkg::tbtc_mode_type mode;
        logic [7:0] count;
        logic [7:0] rd_ptr;
        logic [7:0] rd_data;
        logic tx_v;
        logic [7:0] tx_d;
        logic flag;
        logic halt;
    } tbtc_st_type;
    tbtc_st_type st_reg, st_next;
    logic [7:0] store [256];
    logic wr_en;
    logic [7:0] wr_addr, wr_data;
    logic soft_rst, rst_all;
    logic rx_v;
    logic [7:0] rx_d;
    logic fifo_out_v, fifo_out_rdy, fifo_in_rdy;
    logic [7:0] fifo_out_d;
    logic uart_flag, uart_tx_rdy;

    ////////////////////////////////////////////////////////////////////////
    // serial engine and transmit buffer
    tbtc_uart u_uart (
        .clk(clk),
        .reset_n(rst_all),
        .bit_div(BIT_DIV),
        .sense_in(sense_in),
        .flag_out(uart_flag),
        .rx_valid(rx_v),
        .rx_data(rx_d),
        .tx_valid(fifo_out_v),
        .tx_ready(fifo_out_rdy),
        .tx_data(fifo_out_d)
    );
    assign uart_tx_rdy = fifo_out_rdy;

    tbtc_fifo #(.WIDTH(tbtc_pkg::DATA_W), .DEPTH(tbtc_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(rst_all),
        .flush(1'b0),
        .in_valid(st_reg.tx_v),
        .in_ready(fifo_in_rdy),
        .in_data(st_reg.tx_d),
        .out_valid(fifo_out_v),
        .out_ready(uart_tx_rdy),
        .out_data(fifo_out_d)
    );

    // reset from pin or from the control-R character
    assign soft_rst = rx_v && rx_d == tbtc_pkg::CH_RESET;
    assign rst_all = reset_n && !st_reg.er2 && st_reg.mode != tbtc_pkg::TBTC_RESET;

    ////////////////////////////////////////////////////////////////////////
    // character interpreter
    always_comb begin
        st_next = st_reg;
        st_next.er1 = ext_reset;
        st_next.er2 = st_reg.er1;
        st_next.flag = uart_flag;
        wr_en = 1'b0;
        wr_addr = st_reg.count;
        wr_data = rx_d;
        // a queued character leaves once the buffer takes it
        if (st_reg.tx_v && fifo_in_rdy) st_next.tx_v = 1'b0;
        case (st_reg.mode)
            tbtc_pkg::TBTC_RESET: begin
                st_next.mode = tbtc_pkg::TBTC_IDLE;
            end
            tbtc_pkg::TBTC_PRINT_RD: begin
                // store read is registered; data ready next cycle
                st_next.mode = tbtc_pkg::TBTC_PRINT_WAIT;
            end
            tbtc_pkg::TBTC_PRINT_WAIT: begin
                // leave only once the last character has reached the buffer
                if (!st_reg.tx_v) begin
                    if (st_reg.rd_ptr >= st_reg.count) begin
                        st_next.mode = tbtc_pkg::TBTC_IDLE;
                    end else if (st_reg.rd_data == tbtc_pkg::CH_STOP) begin
                        st_next.mode = tbtc_pkg::TBTC_HALTED;
                        st_next.rd_ptr = st_reg.rd_ptr + 8'h01;
                    end else begin
                        st_next.tx_v = 1'b1;
                        st_next.tx_d = st_reg.rd_data;
                        st_next.rd_ptr = st_reg.rd_ptr + 8'h01;
                        st_next.mode = tbtc_pkg::TBTC_PRINT_RD;
                    end
                end
            end
            default: begin
                // idle or halted: interpret arriving characters
                if (rx_v && !soft_rst) begin
                    if (rx_d == tbtc_pkg::CH_DELETE) begin
                        if (st_reg.count == 8'h00) begin
                            st_next.tx_v = 1'b1;
                            st_next.tx_d = tbtc_pkg::CH_BELL;
                        end else begin
                            // echo the removed character; a halted print stays halted
                            st_next.count = st_reg.count - 8'h01;
                            st_next.tx_v = 1'b1;
                            st_next.tx_d = st_reg.rd_data;
                        end
                    end else if (rx_d == tbtc_pkg::CH_ERASE) begin
                        st_next.count = 8'h00;
                        st_next.mode = tbtc_pkg::TBTC_IDLE;
                    end else if (rx_d == tbtc_pkg::CH_PRINT) begin
                        if (st_reg.count == 8'h00) begin
                            st_next.tx_v = 1'b1;
                            st_next.tx_d = tbtc_pkg::CH_BELL;
                            st_next.mode = tbtc_pkg::TBTC_IDLE;
                        end else begin
                            st_next.rd_ptr = 8'h00;
                            st_next.mode = tbtc_pkg::TBTC_PRINT_RD;
                        end
                    end else if (rx_d == tbtc_pkg::CH_CONT &&
                                 st_reg.mode == tbtc_pkg::TBTC_HALTED) begin
                        if (st_reg.rd_ptr >= st_reg.count) begin
                            st_next.mode = tbtc_pkg::TBTC_IDLE;
                        end else begin
                            st_next.mode = tbtc_pkg::TBTC_PRINT_RD;
                        end
                    end else if (rx_d == tbtc_pkg::CH_CONT) begin
                        st_next.mode = st_reg.mode;
                    end else if (st_reg.count >= STORE_MAX) begin
                        st_next.tx_v = 1'b1;
                        st_next.tx_d = tbtc_pkg::CH_BELL;
                    end else begin
                        wr_en = 1'b1;
                        st_next.count = st_reg.count + 8'h01;
                    end
                end
            end
        endcase
        if (soft_rst) st_next.mode = tbtc_pkg::TBTC_RESET;
        st_next.halt = st_next.mode == tbtc_pkg::TBTC_HALTED; // registered status
    end

    ////////////////////////////////////////////////////////////////////////
    // character store and state register
    always_ff @(posedge clk) begin
        if (wr_en) store[wr_addr] <= wr_data;
    end

    // read port: print pointer, or last character for delete echo
    always_ff @(posedge clk) begin
        if (!rst_all) begin
            st_reg <= '0;
            st_reg.flag <= 1'b1;
            st_reg.er1 <= st_next.er1 & reset_n;
            st_reg.er2 <= 1'b0;
            st_reg.mode <= tbtc_pkg::TBTC_IDLE;
        end else begin
            st_reg <= st_next;
            if (st_next.mode == tbtc_pkg::TBTC_PRINT_WAIT) begin
                st_reg.rd_data <= store[st_reg.rd_ptr];
            end else begin
                st_reg.rd_data <= store[st_next.count - 8'h01];
            end
        end
    end

    // outputs
    assign flag_out = st_reg.flag;
    assign stored_count = st_reg.count;
    assign halted = st_reg.halt;

    ////////////////////////////////////////////////////////////////////////
    // checks on the interpreter
    logic cmd_window;
    logic is_cmd;

    // characters other than control-R are interpreted only while idle or halted
    assign cmd_window = st_reg.mode == tbtc_pkg::TBTC_IDLE ||
        st_reg.mode == tbtc_pkg::TBTC_HALTED;
    assign is_cmd = rx_d == tbtc_pkg::CH_DELETE || rx_d == tbtc_pkg::CH_ERASE ||
        rx_d == tbtc_pkg::CH_PRINT || rx_d == tbtc_pkg::CH_CONT || rx_d == tbtc_pkg::CH_RESET;

    // a plain character is appended below the limit
    property p_append;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && !is_cmd && st_reg.count < STORE_MAX
            |=> st_reg.count == $past(st_reg.count) + 8'h01;
    endproperty
    a_append: assert property (p_append) else $error("character not appended");

    // a full store drops the character and rings the bell
    property p_full_bell;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && !is_cmd && st_reg.count == STORE_MAX
            |=> st_reg.count == STORE_MAX && st_reg.tx_v && st_reg.tx_d == tbtc_pkg::CH_BELL;
    endproperty
    a_full_bell: assert property (p_full_bell) else $error("full store no bell");

    // delete shortens the store and echoes the removed character
    property p_delete_echo;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && rx_d == tbtc_pkg::CH_DELETE && st_reg.count != 8'h00
            |=> st_reg.count == $past(st_reg.count) - 8'h01 && st_reg.tx_v &&
            st_reg.tx_d == store[st_reg.count];
    endproperty
    a_delete_echo: assert property (p_delete_echo) else $error("delete echo wrong");

    // delete on an empty store rings the bell
    property p_delete_empty;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && rx_d == tbtc_pkg::CH_DELETE && st_reg.count == 8'h00
            |=> st_reg.count == 8'h00 && st_reg.tx_v && st_reg.tx_d == tbtc_pkg::CH_BELL;
    endproperty
    a_delete_empty: assert property (p_delete_empty) else $error("empty delete no bell");

    // erase leaves an empty store
    property p_erase;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && rx_d == tbtc_pkg::CH_ERASE
            |=> st_reg.count == 8'h00 && !st_reg.halt;
    endproperty
    a_erase: assert property (p_erase) else $error("erase left text");

    // print of an empty store rings the bell
    property p_print_empty;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && rx_d == tbtc_pkg::CH_PRINT && st_reg.count == 8'h00
            |=> st_reg.tx_v && st_reg.tx_d == tbtc_pkg::CH_BELL && !st_reg.halt;
    endproperty
    a_print_empty: assert property (p_print_empty) else $error("empty print no bell");

    // print starts from the first stored character
    property p_print_start;
        @(posedge clk) disable iff (!rst_all)
        cmd_window && rx_v && rx_d == tbtc_pkg::CH_PRINT && st_reg.count != 8'h00
            |=> st_reg.mode == tbtc_pkg::TBTC_PRINT_RD && st_reg.rd_ptr == 8'h00;
    endproperty
    a_print_start: assert property (p_print_start) else $error("print not from start");

    // print ends once every stored character is queued
    property p_print_end;
        @(posedge clk) disable iff (!rst_all)
        st_reg.mode == tbtc_pkg::TBTC_PRINT_WAIT && !st_reg.tx_v && st_reg.rd_ptr >= st_reg.count
            |=> st_reg.mode == tbtc_pkg::TBTC_IDLE;
    endproperty
    a_print_end: assert property (p_print_end) else $error("print did not end");

    // a stop marker read during print halts without sending
    property p_stop_halt;
        @(posedge clk) disable iff (!rst_all)
        st_reg.mode == tbtc_pkg::TBTC_PRINT_WAIT && !st_reg.tx_v &&
        st_reg.rd_ptr < st_reg.count && store[st_reg.rd_ptr] == tbtc_pkg::CH_STOP
            |=> st_reg.halt && !st_reg.tx_v;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("marker did not halt");

    // the marker itself is never queued by print
    property p_no_stop_out;
        @(posedge clk) disable iff (!rst_all)
        !cmd_window && st_reg.tx_v |-> st_reg.tx_d != tbtc_pkg::CH_STOP;
    endproperty
    a_no_stop_out: assert property (p_no_stop_out) else $error("marker was printed");

    // continue resumes just after the marker
    property p_cont;
        @(posedge clk) disable iff (!rst_all)
        st_reg.mode == tbtc_pkg::TBTC_HALTED && rx_v && rx_d == tbtc_pkg::CH_CONT &&
        st_reg.rd_ptr < st_reg.count |=> st_reg.mode == tbtc_pkg::TBTC_PRINT_RD &&
        st_reg.rd_ptr == $past(st_reg.rd_ptr);
    endproperty
    a_cont: assert property (p_cont) else $error("continue did not resume");

    // control-R clears the logic two cycles later
    property p_soft_reset;
        @(posedge clk) disable iff (!reset_n)
        soft_rst |=> st_reg.mode == tbtc_pkg::TBTC_RESET ##1 st_reg.count == 8'h00 && !st_reg.halt;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");
endmodule : tbtc_ctrl

// [tbtc_pkg.sv]
// Notes on behaviour
// - store up to 250 appended characters
// - serial out on flag, in on sense
// - bit rate divided from system clock
// - delete removes last char and echoes it
// - control-E empties the whole store
// - stop marker stored, never printed
// - print halts at stop marker
// - control-C resumes after the marker
// - control-P prints from first character
// - print until end or next marker
// - reset pin and control-R reset alike
// - full store: discard, ring bell
// - print of empty store rings bell
// - delete on empty store rings bell
package tbtc_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BAUD_DEFAULT = 300;
    localparam int unsigned STORE_MAX = 250;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_CHAR = 4'hA;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [7:0] CH_DELETE = 8'h7F;
    localparam logic [7:0] CH_STOP = 8'h02;
    localparam logic [7:0] CH_CONT = 8'h03;
    localparam logic [7:0] CH_ERASE = 8'h05;
    localparam logic [7:0] CH_PRINT = 8'h10;
    localparam logic [7:0] CH_RESET = 8'h12;
    localparam logic [7:0] CH_BELL = 8'h07;
    typedef enum logic [2:0] {
        TBTC_IDLE, TBTC_PRINT_RD, TBTC_PRINT_WAIT, TBTC_HALTED, TBTC_RESET
    } tbtc_mode_type;
endpackage : tbtc_pkg

// [tbtc_fifo.sv]
`timescale 1ns/1ns
module tbtc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    // write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // read side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tbtc_fifo_st_type;
    tbtc_fifo_st_type st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr, do_rd;

    // handshakes and flags
    assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (st_reg.cnt != '0);
    assign out_data = mem[st_reg.rp];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready && !flush;

    // pointer and count update
    always_comb begin
        st_next = st_reg;
        if (do_wr) st_next.wp = st_reg.wp + AW'(1);
        if (do_rd) st_next.rp = st_reg.rp + AW'(1);
        st_next.cnt = st_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        if (flush) st_next = '0;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) st_reg <= '0;
        else st_reg <= st_next;
        if (do_wr) mem[st_reg.wp] <= in_data;
    end
endmodule : tbtc_fifo

// [tbtc_uart.sv]
`timescale 1ns/1ns
module tbtc_uart (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [17:0] bit_div,
    // serial pins
    input wire logic sense_in,
    output logic flag_out,
    // receive stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    // transmit stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data
);
    typedef struct packed {
        logic s1, s2;
        logic rx_busy;
        logic [17:0] rx_tmr;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_v;
        logic tx_busy;
        logic [17:0] tx_tmr;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
    } tbtc_uart_st_type;
    tbtc_uart_st_type st_reg, st_next;

    assign flag_out = st_reg.tx_sh[0];
    assign rx_valid = st_reg.rx_v;
    assign rx_data = st_reg.rx_sh;
    assign tx_ready = !st_reg.tx_busy;

    // bit timing derived from clock divider, mid-bit receive sampling
    always_comb begin
        st_next = st_reg;
        st_next.s1 = sense_in;
        st_next.s2 = st_reg.s1;
        st_next.rx_v = 1'b0;
        if (!st_reg.rx_busy) begin
            if (!st_reg.s2) begin // start bit seen
                st_next.rx_busy = 1'b1;
                st_next.rx_tmr = {1'b0, bit_div[17:1]};
                st_next.rx_bit = '0;
            end
        end else if (st_reg.rx_tmr != '0) begin
            st_next.rx_tmr = st_reg.rx_tmr - 18'h00001;
        end else begin
            st_next.rx_tmr = bit_div;
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == 4'h0 && st_reg.s2) begin
                st_next.rx_busy = 1'b0; // glitch, not a start bit
            end else if (st_reg.rx_bit == tbtc_pkg::DATA_BITS + 4'h1) begin
                st_next.rx_busy = 1'b0;
                st_next.rx_v = st_reg.s2; // frame kept only with a high stop bit
            end else if (st_reg.rx_bit != 4'h0) begin
                st_next.rx_sh = {st_reg.s2, st_reg.rx_sh[7:1]}; // lsb first
            end
        end
        // transmitter
        if (!st_reg.tx_busy) begin
            if (tx_valid) begin
                st_next.tx_busy = 1'b1;
                st_next.tx_sh = {1'b1, tx_data, 1'b0};
                st_next.tx_tmr = bit_div;
                st_next.tx_bit = '0;
            end
        end else if (st_reg.tx_tmr != '0) begin
            st_next.tx_tmr = st_reg.tx_tmr - 18'h00001;
        end else begin
            st_next.tx_tmr = bit_div;
            st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
            st_next.tx_bit = st_reg.tx_bit + 4'h1;
            if (st_reg.tx_bit == tbtc_pkg::BITS_PER_CHAR - 4'h1) st_next.tx_busy = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.s1 <= 1'b1;
            st_reg.s2 <= 1'b1;
            st_reg.tx_sh <= 10'h3FF;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : tbtc_uart

// [tbtc_term.sv]
`timescale 1ns/1ns
module tbtc_term #(
    parameter int unsigned BIT_CYC = 20
) (
    // clock
    input wire logic clk,
    // serial pins
    output logic sense_in,
    input wire logic flag_out
);
    logic [7:0] rx_q[$];

    ////////////////////////////////////////////////////////////////////////////////
    // line rests high between frames
    initial sense_in = 1'b1;

    // one frame: low start, eight bits lsb first, two high stops
    task automatic send_char(input logic [7:0] c);
        logic [10:0] frame;
        frame = {2'b11, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge clk);
            sense_in <= frame[i];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
    endtask : send_char

    ////////////////////////////////////////////////////////////////////////////////
    // receiver samples mid-bit; a bad stop bit stores a null, never expected
    always begin
        logic [7:0] d;
        @(negedge flag_out);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            d[i] = flag_out; // lsb first
        end
        repeat (BIT_CYC) @(posedge clk);
        if (flag_out === 1'b1) rx_q.push_back(d); // stop bit high
        else rx_q.push_back(8'h00);
    end
endmodule : tbtc_term

// [text_buffer_typewriter_ctrl_tb_top.sv]
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module text_buffer_typewriter_ctrl_tb_top;
    localparam int unsigned BAUD = 1000000;
    localparam int unsigned BIT_CYC = tbtc_pkg::CLK_HZ / BAUD;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ext_reset = 1'b0;
    logic sense_in;
    logic flag_out;
    logic [7:0] stored_count;
    logic halted;
    int miscompares = 0;
    int samples_checked = 0;
    int unsigned rnd = 16;
    byte unsigned store_q[$];
    byte unsigned exp_q[$];
    int print_pos = 0;
    bit model_halted = 1'b0;

    always #25 clk = ~clk;

    tbtc_ctrl #(.BAUD(BAUD)) uut (.clk(clk), .reset_n(reset_n), .ext_reset(ext_reset),
        .sense_in(sense_in), .flag_out(flag_out), .stored_count(stored_count), .halted(halted));
    tbtc_term #(.BIT_CYC(BIT_CYC)) term (.clk(clk), .sense_in(sense_in), .flag_out(flag_out));

    ////////////////////////////////////////////////////////////////////////////////
    // printable random characters from an xorshift generator
    function automatic byte unsigned rnd_char();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return 8'(32'h20 + rnd % 32'h5F);
    endfunction : rnd_char

    // reference print: send from print_pos until end or a stop marker
    function automatic void model_print();
        model_halted = 1'b0;
        while (print_pos < store_q.size()) begin
            print_pos++;
            if (store_q[print_pos - 1] == tbtc_pkg::CH_STOP) begin
                model_halted = 1'b1;
                return;
            end
            exp_q.push_back(store_q[print_pos - 1]);
        end
    endfunction : model_print

    // reference reaction to one received character
    function automatic void model_apply(input byte unsigned c);
        case (c)
            tbtc_pkg::CH_DELETE: begin
                if (store_q.size() == 0) exp_q.push_back(tbtc_pkg::CH_BELL);
                else exp_q.push_back(store_q.pop_back());
            end
            tbtc_pkg::CH_ERASE, tbtc_pkg::CH_RESET: begin
                store_q.delete();
                model_halted = 1'b0;
            end
            tbtc_pkg::CH_PRINT: begin
                print_pos = 0;
                model_halted = 1'b0;
                if (store_q.size() == 0) exp_q.push_back(tbtc_pkg::CH_BELL);
                else model_print();
            end
            tbtc_pkg::CH_CONT: if (model_halted) model_print();
            default: begin
                if (store_q.size() >= tbtc_pkg::STORE_MAX) exp_q.push_back(tbtc_pkg::CH_BELL);
                else store_q.push_back(c);
            end
        endcase
    endfunction : model_apply

    ////////////////////////////////////////////////////////////////////////////////
    // send one character and compare the stored count
    task automatic type_char(input byte unsigned c);
        model_apply(c);
        term.send_char(c);
        repeat (3) @(negedge clk);
        `CHK(stored_count, 8'(store_q.size()))
    endtask : type_char

    // wait for replies, then compare them and the halt flag
    task automatic flush_check(input string name);
        int n;
        n = 0;
        while (term.rx_q.size() < exp_q.size() && n < 20000) begin
            @(negedge clk);
            n++;
        end
        repeat (12 * BIT_CYC) @(negedge clk);
        `CHK(term.rx_q.size(), exp_q.size())
        foreach (exp_q[i]) if (i < term.rx_q.size()) `CHK(term.rx_q[i], exp_q[i])
        `CHK(halted, model_halted)
        term.rx_q.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask : flush_check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized for the fill test plus the short ones
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        `CHK(stored_count, 8'h00)
        `CHK(flag_out, 1'b1)
        type_char(tbtc_pkg::CH_DELETE);
        type_char(tbtc_pkg::CH_PRINT);
        flush_check("empty");
        // text with a marker, then delete the last character
        for (int i = 0; i < 6; i++) begin
            type_char(i == 2 ? tbtc_pkg::CH_STOP : (i == 5 ? tbtc_pkg::CH_DELETE : rnd_char()));
        end
        flush_check("delete");
        type_char(tbtc_pkg::CH_PRINT);
        flush_check("print halt");
        // text typed while halted is stored and printed on continue
        type_char(rnd_char());
        `CHK(halted, 1'b1)
        type_char(tbtc_pkg::CH_CONT);
        flush_check("continue");
        type_char(tbtc_pkg::CH_CONT);
        flush_check("continue ignored");
        type_char(tbtc_pkg::CH_ERASE);
        type_char(tbtc_pkg::CH_PRINT);
        flush_check("erase");
        // fill the store and overflow by one
        for (int i = 0; i < 251; i++) type_char(rnd_char());
        flush_check("full");
        type_char(tbtc_pkg::CH_RESET);
        flush_check("soft reset");
        // external reset pin empties the store
        type_char(rnd_char());
        ext_reset = 1'b1;
        repeat (4) @(negedge clk);
        ext_reset = 1'b0;
        repeat (5) @(negedge clk);
        store_q.delete();
        `CHK(stored_count, 8'h00)
        flush_check("pin reset");
        end_of_test();
    end
endmodule : text_buffer_typewriter_ctrl_tb_top
